/* core/rbs_pkg.sv */
// Constants, types and register map of the broadcast scheduler.
// Assumes a 10 MHz system clock and a 32-bit APB register bus.
package rbs_pkg;

    localparam int CLK_PERIOD_NS    = 100;
    localparam int SEC_NS           = 1_000_000_000;
    localparam int SEC_CYC          = SEC_NS / CLK_PERIOD_NS;
    localparam int RETRY_GAP_MS     = 200;
    localparam int RETRY_GAP_CYC    = RETRY_GAP_MS * 1_000_000
                                      / CLK_PERIOD_NS;
    localparam int RAPID_GAP_US     = 10;
    localparam int RAPID_GAP_CYC    = RAPID_GAP_US * 1_000 / CLK_PERIOD_NS;
    localparam int ACK_WAIT_MS      = 50;
    localparam int ACK_WAIT_CYC     = ACK_WAIT_MS * 1_000_000
                                      / CLK_PERIOD_NS;

    localparam logic [16:0] ALARM_GAP_S  = 17'h00006;
    localparam logic [16:0] SEC_PER_MIN  = 17'h0003C;
    localparam logic [16:0] SEC_PER_HOUR = 17'h00E10;
    localparam logic [2:0]  HOLD_S       = 3'h5;
    localparam logic [1:0]  FLASH_S      = 2'h2;

    localparam logic [2:0]  WAKE_MIN     = 3'h1;
    localparam logic [2:0]  WAKE_MAX     = 3'h5;
    localparam logic [2:0]  WAKE_DEF     = 3'h5;
    localparam logic [2:0]  RETRY_MIN    = 3'h1;
    localparam logic [2:0]  RETRY_MAX    = 3'h5;
    localparam logic [2:0]  RETRY_DEF    = 3'h1;
    localparam logic [2:0]  RETRY_ACK    = 3'h4;
    localparam logic [1:0]  REPEATS      = 2'h3;
    localparam logic [4:0]  CFG_HRS_MAX  = 5'h12;
    localparam logic [4:0]  CFG_HRS_DEF  = 5'h01;
    localparam logic [4:0]  NET_ID_MAX   = 5'h19;
    localparam logic [4:0]  NET_ENC_MIN  = 5'h0C;
    localparam logic [4:0]  RTU_MAX      = 5'h1F;
    localparam logic [4:0]  RTU_MAX_DUAL = 5'h1E;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;

    localparam logic [1:0] PWR_10MW  = 2'h0;
    localparam logic [1:0] PWR_1W    = 2'h3;
    localparam logic [2:0] PWR_125MW = 3'h4;

    localparam logic [7:0] OFS_LINK   = 8'h00;
    localparam logic [7:0] OFS_TIMING = 8'h04;
    localparam logic [7:0] OFS_RADIO  = 8'h08;
    localparam logic [7:0] OFS_CMD    = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CNT0   = 8'h14;
    localparam logic [7:0] OFS_CNT1   = 8'h18;

    // LINK: net_id[4:0] rtu[12:8] dual[16]
    localparam int F_RTU  = 8;
    localparam int F_DUAL = 16;
    // TIMING: wake_min[2:0] retries[10:8] cfg_hours[20:16]
    localparam int F_RETRY = 8;
    localparam int F_CFGH  = 16;
    // RADIO: handshake[0] band_24g[1] power[5:4] link_screen[8]
    localparam int F_BAND  = 1;
    localparam int F_PWR   = 4;
    localparam int F_SCRN  = 8;
    // CMD: clear cnt0[0] clear cnt1[1] config edited[2]
    localparam int F_EDIT  = 2;
    // STATUS: state[2:0] in_range[4] unlocked[5] cfg_pending[6]
    localparam int F_INRG  = 4;
    localparam int F_UNLK  = 5;
    localparam int F_PEND  = 6;

    typedef enum logic [2:0] {
        ST_SLEEP, ST_WAKE, ST_SEND, ST_BUSY, ST_ACK, ST_GAP, ST_RETRY
    } rbs_state_e;

    typedef struct packed {
        logic       in_range;
        logic [4:0] net_id;
        logic       ack;
        logic       tx_done;
    } rbs_radio_in_s;

    typedef struct packed {
        logic       radio_on;
        logic       tx_start;
        logic       tx_cfg;
        logic       tx_chan;
        logic [4:0] rtu;
        logic [4:0] hop_chan;
        logic       encrypt;
        logic [2:0] power;
    } rbs_radio_out_s;

endpackage

/* core/rbs_scheduler.sv */
// Broadcast scheduler of a wireless gas monitor: timing, repeats,
// config broadcasts, identifiers, power and per-channel counters.
// Assumes a radio module that reports server range, ack and tx done.
`timescale 1ns/100ps
module rbs_scheduler
    import rbs_pkg::*;
#(
    parameter int SEC_CYCLES       = SEC_CYC,
    parameter int RETRY_GAP_CYCLES = RETRY_GAP_CYC,
    parameter int ACK_WAIT_CYCLES  = ACK_WAIT_CYC,
    parameter int RAPID_GAP_CYCLES = RAPID_GAP_CYC
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic                pslverr,
    output logic [31:0]         prdata,
    input  wire logic           first_level_alarm,
    input  wire logic           second_level_alarm,
    input  wire logic           third_level_alarm,
    input  wire logic           up_key,
    input  wire logic           radio_menu_end,
    input  wire rbs_radio_in_s  radio_in,
    output rbs_radio_out_s      radio_out,
    output logic                alarm_led_flash
);

    typedef struct packed {
        rbs_state_e       st;
        logic [31:0]      tick;
        logic [31:0]      cyc;
        logic [16:0]      sec;
        logic [16:0]      cfg_sec;
        logic [2:0]       hold;
        logic [1:0]       flash;
        logic [4:0]       net_id;
        logic [4:0]       rtu;
        logic             dual;
        logic [2:0]       wake_min;
        logic [2:0]       retries;
        logic [4:0]       cfg_hours;
        logic             handshake;
        logic             band_24g;
        logic [1:0]       power;
        logic             link_screen;
        logic             unlocked;
        logic             cfg_pending;
        logic             cfg_sending;
        logic             chan;
        logic [2:0]       tries;
        logic [1:0]       reps;
        logic             acked;
        logic             in_range;
        logic [1:0][15:0] cnt;
        logic             tx_start;
        logic [31:0]      prdata;
    } rbs_regs_s;

    rbs_regs_s        q;
    rbs_regs_s        next_q;
    logic [1:0][15:0] next_cnt;
    logic [31:0]      rd_val;
    logic             hit;
    logic             wr;
    logic             live_range;
    logic             ack_ok;
    logic             radio_on;

    function automatic logic [2:0] clamp3(input logic [2:0] v,
                                          input logic [2:0] lo,
                                          input logic [2:0] hi);
        logic [2:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    function automatic logic [4:0] clamp5(input logic [4:0] v,
                                          input logic [4:0] hi);
        return (v > hi) ? hi : v;
    endfunction

    assign wr         = psel & penable & pwrite;
    // A server of another network never counts as in range
    assign live_range = radio_in.in_range
                        && (radio_in.net_id == q.net_id);
    assign ack_ok     = radio_in.ack
                        && (radio_in.net_id == q.net_id);
    assign radio_on   = (q.st != ST_SLEEP) || q.link_screen;

    // Clear and increment in one cycle leaves a count of one
    for (genvar ch = 0; ch < 2; ch++) begin : g_cnt
        logic inc;
        logic clr;
        assign inc = (q.st == ST_SEND) && (q.chan == ch);
        assign clr = wr && (paddr == OFS_CMD) && pwdata[ch];
        always_comb begin
            if (clr) begin
                next_cnt[ch] = {15'h0000, inc};
            end else if (inc && q.cnt[ch] != CNT_MAX) begin
                next_cnt[ch] = q.cnt[ch] + 16'h0001;
            end else begin
                next_cnt[ch] = q.cnt[ch];
            end
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        hit    = 1'b1;
        if (paddr == OFS_LINK) begin
            rd_val[4:0]                = q.net_id;
            rd_val[F_RTU +: 5]         = q.rtu;
            rd_val[F_DUAL]             = q.dual;
        end else if (paddr == OFS_TIMING) begin
            rd_val[2:0]                = q.wake_min;
            rd_val[F_RETRY +: 3]       = q.retries;
            rd_val[F_CFGH +: 5]        = q.cfg_hours;
        end else if (paddr == OFS_RADIO) begin
            rd_val[0]                  = q.handshake;
            rd_val[F_BAND]             = q.band_24g;
            rd_val[F_PWR +: 2]         = q.power;
            rd_val[F_SCRN]             = q.link_screen;
        end else if (paddr == OFS_CMD) begin
            rd_val = 32'h0000_0000;
        end else if (paddr == OFS_STATUS) begin
            rd_val[2:0]                = q.st;
            rd_val[F_INRG]             = q.in_range;
            rd_val[F_UNLK]             = q.unlocked;
            rd_val[F_PEND]             = q.cfg_pending;
        end else if (paddr == OFS_CNT0) begin
            rd_val[15:0]               = q.cnt[0];
        end else if (paddr == OFS_CNT1) begin
            rd_val[15:0]               = q.cnt[1];
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        logic        tick_hit;
        logic        burst_end;
        logic        stop;
        logic        fire;
        logic [2:0]  tries_n;
        logic [16:0] target;
        logic [16:0] cfg_target;
        tick_hit   = (q.tick == 32'(SEC_CYCLES - 1));
        burst_end  = 1'b0;
        stop       = 1'b0;
        fire       = 1'b0;
        tries_n    = q.tries + 3'h1;
        target     = 17'(q.wake_min * SEC_PER_MIN);
        cfg_target = 17'(q.cfg_hours * SEC_PER_HOUR);
        if (first_level_alarm || second_level_alarm
                || third_level_alarm) begin
            target = ALARM_GAP_S;
        end

        next_q          = q;
        next_q.tx_start = 1'b0;
        next_q.cnt      = next_cnt;
        next_q.tick     = tick_hit ? 32'h0000_0000 : q.tick + 32'h1;
        next_q.cyc      = q.cyc + 32'h1;
        if (tick_hit && q.sec != 17'h1FFFF) begin
            next_q.sec = q.sec + 17'h1;
        end
        if (radio_on) begin
            next_q.in_range = live_range;
        end
        if (q.st != ST_SLEEP && ack_ok) begin
            next_q.acked = 1'b1;
        end

        case (q.st)
            ST_SLEEP: begin
                if (q.sec >= target || q.cfg_pending) begin
                    next_q.st          = ST_WAKE;
                    next_q.cfg_sending = q.cfg_pending;
                    next_q.chan        = 1'b0;
                    next_q.tries       = 3'h0;
                    next_q.reps        = 2'h0;
                    next_q.acked       = 1'b0;
                end
            end
            ST_WAKE: begin
                if (live_range) begin
                    next_q.st = ST_SEND;
                end
            end
            ST_SEND: begin
                next_q.tx_start = 1'b1;
                next_q.st       = ST_BUSY;
            end
            ST_BUSY: begin
                if (radio_in.tx_done) begin
                    next_q.reps = q.reps + 2'h1;
                    next_q.cyc  = 32'h0;
                    if (q.handshake) begin
                        next_q.st = ST_ACK;
                    end else if (q.reps + 2'h1 < REPEATS) begin
                        next_q.st = ST_GAP;
                    end else begin
                        burst_end = 1'b1;
                    end
                end
            end
            ST_ACK: begin
                if (ack_ok || q.acked) begin
                    burst_end = 1'b1;
                end else if (q.cyc == 32'(ACK_WAIT_CYCLES - 1)) begin
                    next_q.cyc = 32'h0;
                    if (q.reps < REPEATS) begin
                        next_q.st = ST_GAP;
                    end else begin
                        burst_end = 1'b1;
                    end
                end
            end
            ST_GAP: begin
                if (q.cyc == 32'(RAPID_GAP_CYCLES - 1)) begin
                    next_q.st = ST_SEND;
                end
            end
            ST_RETRY: begin
                if (q.cyc == 32'(RETRY_GAP_CYCLES - 1)) begin
                    next_q.st    = ST_SEND;
                    next_q.reps  = 2'h0;
                    next_q.acked = 1'b0;
                end
            end
            default: begin
                next_q.st = ST_SLEEP;
            end
        endcase

        if (burst_end) begin
            stop = (tries_n >= q.retries);
            if (q.retries >= RETRY_ACK && (q.acked || ack_ok)) begin
                stop = 1'b1;
            end
            if (!stop) begin
                next_q.st    = ST_RETRY;
                next_q.cyc   = 32'h0;
                next_q.tries = tries_n;
            end else if (q.dual && !q.chan) begin
                next_q.st    = ST_SEND;
                next_q.chan  = 1'b1;
                next_q.tries = 3'h0;
                next_q.reps  = 2'h0;
                next_q.acked = 1'b0;
            end else begin
                next_q.st  = ST_SLEEP;
                next_q.sec = 17'h0;
                if (q.cfg_sending) begin
                    next_q.cfg_pending = 1'b0;
                    next_q.cfg_sending = 1'b0;
                end
            end
        end

        // Config interval runs on its own, independent of wakeups
        if (q.cfg_hours == 5'h00) begin
            next_q.cfg_sec = 17'h0;
        end else if (tick_hit) begin
            next_q.cfg_sec = q.cfg_sec + 17'h1;
            if (q.cfg_sec + 17'h1 >= cfg_target) begin
                next_q.cfg_sec     = 17'h0;
                next_q.cfg_pending = 1'b1;
            end
        end

        if (!up_key) begin
            next_q.hold = 3'h0;
        end else if (tick_hit && q.hold < HOLD_S) begin
            next_q.hold = q.hold + 3'h1;
            fire        = (q.hold + 3'h1 == HOLD_S);
        end
        if (fire && radio_menu_end) begin
            next_q.unlocked = 1'b1;
            next_q.flash    = FLASH_S;
        end else if (fire) begin
            next_q.cfg_pending = 1'b1;
        end else if (tick_hit && q.flash != 2'h0) begin
            next_q.flash = q.flash - 2'h1;
        end

        if (wr && paddr == OFS_LINK) begin
            next_q.net_id = clamp5(pwdata[4:0], NET_ID_MAX);
            next_q.dual   = pwdata[F_DUAL];
            next_q.rtu    = clamp5(pwdata[F_RTU +: 5],
                                   pwdata[F_DUAL] ? RTU_MAX_DUAL
                                                  : RTU_MAX);
        end else if (wr && paddr == OFS_TIMING) begin
            next_q.wake_min  = clamp3(pwdata[2:0], WAKE_MIN, WAKE_MAX);
            next_q.retries   = clamp3(pwdata[F_RETRY +: 3],
                                      RETRY_MIN, RETRY_MAX);
            next_q.cfg_hours = clamp5(pwdata[F_CFGH +: 5], CFG_HRS_MAX);
        end else if (wr && paddr == OFS_RADIO) begin
            next_q.handshake   = pwdata[0];
            next_q.band_24g    = pwdata[F_BAND];
            next_q.link_screen = pwdata[F_SCRN];
            // Locked 1 W request leaves the old power in place
            if (pwdata[F_PWR +: 2] != PWR_1W || q.unlocked) begin
                next_q.power = pwdata[F_PWR +: 2];
            end
        end
        // Edit request wins over the end-of-sequence clear
        if (wr && paddr == OFS_CMD && pwdata[F_EDIT]) begin
            next_q.cfg_pending = 1'b1;
        end

        if (psel && !penable && !pwrite) begin
            next_q.prdata = rd_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.wake_min  <= WAKE_DEF;
            q.retries   <= RETRY_DEF;
            q.cfg_hours <= CFG_HRS_DEF;
            q.power     <= PWR_10MW;
        end else begin
            q <= next_q;
        end
    end

    assign pready          = 1'b1;
    assign pslverr         = psel & penable & ~hit;
    assign prdata          = q.prdata;
    assign alarm_led_flash = (q.flash != 2'h0);

    always_comb begin
        radio_out.radio_on = radio_on;
        radio_out.tx_start = q.tx_start;
        radio_out.tx_cfg   = q.cfg_sending;
        radio_out.tx_chan  = q.chan;
        radio_out.rtu      = q.rtu + {4'h0, q.chan};
        radio_out.hop_chan = q.net_id + 5'h01;
        radio_out.encrypt  = (q.net_id >= NET_ENC_MIN);
        radio_out.power    = q.band_24g ? PWR_125MW
                                        : {1'b0, q.power};
    end

endmodule

/* bench/rbs_scheduler_asserts.sv */
// Port-level checker for the broadcast scheduler.
// Assumes it is bound into rbs_scheduler and sees its ports only.
`timescale 1ns/100ps
module rbs_scheduler_asserts
    import rbs_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           up_key,
    input  wire logic           radio_menu_end,
    input  wire rbs_radio_in_s  radio_in,
    input  wire rbs_radio_out_s radio_out,
    input  wire logic           alarm_led_flash
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_tx_pulse;
        radio_out.tx_start |=> !radio_out.tx_start [*2];
    endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("tx_start longer than one cycle");
    property p_tx_range;
        radio_out.tx_start |-> radio_out.radio_on
            && $past(radio_in.in_range, 2);
    endproperty
    a_tx_range: assert property (p_tx_range)
        else $error("packet sent without server in range");
    property p_wake_gap;
        $rose(radio_out.radio_on) |-> !radio_out.tx_start [*2];
    endproperty
    a_wake_gap: assert property (p_wake_gap)
        else $error("packet sent as radio powers up");
    property p_enc;
        radio_out.encrypt == (radio_out.hop_chan > 5'h0C);
    endproperty
    a_enc: assert property (p_enc)
        else $error("encryption does not follow network");
    property p_hop;
        radio_out.hop_chan inside {[5'h01:5'h1A]};
    endproperty
    a_hop: assert property (p_hop)
        else $error("hop channel out of range");
    property p_pwr;
        radio_out.power <= 3'h4;
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("power code out of range");
    property p_flash;
        $rose(alarm_led_flash) |-> $past(up_key) && $past(radio_menu_end);
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash without key hold at menu end");
    property p_ack_stop;
        $rose(radio_in.ack) |-> !radio_out.tx_start [*4];
    endproperty
    a_ack_stop: assert property (p_ack_stop)
        else $error("packet resent after acknowledge");

    c_chan1: cover property (radio_out.tx_start && radio_out.tx_chan);
    c_ack: cover property ($rose(radio_in.ack));
    c_flash: cover property ($rose(alarm_led_flash));
endmodule

bind rbs_scheduler rbs_scheduler_asserts rbs_scheduler_asserts_i (
    .pclk(pclk), .presetn(presetn), .up_key(up_key),
    .radio_menu_end(radio_menu_end), .radio_in(radio_in),
    .radio_out(radio_out), .alarm_led_flash(alarm_led_flash));

/* bench/rbs_radio_model.sv */
// Radio module and server model facing the scheduler.
// Assumes the package radio carriers; slow stretches each packet.
`timescale 1ns/100ps
module rbs_radio_model
    import rbs_pkg::*;
(
    input  wire logic           pclk,
    input  wire rbs_radio_out_s radio_out,
    input  wire logic [4:0]     net_id,
    input  wire logic           ack_en,
    input  wire logic           slow,
    output rbs_radio_in_s       radio_in
);
    logic [3:0] busy = 4'h0;
    logic [2:0] ack_dly = 3'h0;

    // Server found as soon as the radio is powered
    assign radio_in.in_range = radio_out.radio_on;
    assign radio_in.net_id   = net_id;
    assign radio_in.tx_done  = (busy == 4'h1);
    assign radio_in.ack      = (ack_dly == 3'h1);

    always @(posedge pclk) begin
        if (radio_out.tx_start === 1'h1)
            busy <= slow ? 4'h6 : 4'h2;
        else if (busy != 4'h0)
            busy <= busy - 4'h1;
        if (radio_in.tx_done && ack_en)
            ack_dly <= 3'h3;
        else if (ack_dly != 3'h0)
            ack_dly <= ack_dly - 3'h1;
    end
endmodule

/* bench/rbs_scheduler_tb.sv */
// Self-checking bench for the broadcast scheduler.
// Assumes rbs_radio_model as far side and the bound checker.
`timescale 1ns/100ps
module rbs_scheduler_tb
    import rbs_pkg::*;
;
    localparam int S = 20;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, perr, flash, rtu_ok;
    logic ack_en = 1'h0, slow = 1'h0, up_key = 1'h0, m_end = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] alm = 3'h0;
    logic [4:0] mnet = 5'h00;
    rbs_radio_in_s radio_in;
    rbs_radio_out_s radio_out;
    int err_count = 0, checks_done = 0, ntx = 0, ncfg = 0, waited;

    always #50 pclk = ~pclk;

    rbs_scheduler #(.SEC_CYCLES(S), .RETRY_GAP_CYCLES(8),
        .ACK_WAIT_CYCLES(10), .RAPID_GAP_CYCLES(4)) rbs_scheduler_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .first_level_alarm(alm[0]),
        .second_level_alarm(alm[1]), .third_level_alarm(alm[2]),
        .up_key(up_key), .radio_menu_end(m_end), .radio_in(radio_in),
        .radio_out(radio_out), .alarm_led_flash(flash));
    rbs_radio_model rbs_radio_model_i (.pclk(pclk),
        .radio_out(radio_out), .net_id(mnet), .ack_en(ack_en),
        .slow(slow), .radio_in(radio_in));

    always @(posedge pclk)
        if (radio_out.tx_start === 1'h1) begin
            ntx <= ntx + 1;
            ncfg <= ncfg + int'(radio_out.tx_cfg === 1'h1);
            if (radio_out.tx_chan === 1'h1)
                rtu_ok <= (radio_out.rtu === 5'h06);
        end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Slave sets the wait states; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        perr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, rd, e);
    endtask

    task automatic till(input logic v, input int lim);
        waited = 0;
        while (radio_out.radio_on !== v && waited < lim) begin
            @(posedge pclk);
            waited++;
        end
        if (waited >= lim)
            chk("radio wait", 32'h0, 32'h1);
    endtask

    // Command write, then one full broadcast sequence
    task automatic go(input logic [31:0] cmd);
        wr(OFS_CMD, cmd);
        till(1'h1, 50);
        till(1'h0, 3000);
    endtask

    task automatic t_reset;
        chk("hop", radio_out.hop_chan, 5'h01);
        rdc(OFS_TIMING, 32'h0001_0105, "timing");
        rdc(OFS_CNT0, 32'h0, "cnt0");
        rdc(OFS_CNT1, 32'h0, "cnt1");
        apb(1'h0, 8'h1C, 32'h0);
        chk("pslverr", perr, 1'h1);
        $display("test reset done");
    endtask

    task automatic t_ids;
        logic [4:0] wv [3] = '{5'h1F, 5'h0B, 5'h0C};
        logic [4:0] nv [3] = '{5'h19, 5'h0B, 5'h0C};
        for (int i = 0; i < 3; i++) begin
            wr(OFS_LINK, {27'h0, wv[i]});
            rdc(OFS_LINK, {27'h0, nv[i]}, "net_id");
            chk("hop", radio_out.hop_chan, nv[i] + 5'h01);
            chk("enc", radio_out.encrypt, nv[i] >= 5'h0C);
        end
        wr(OFS_LINK, 32'h0001_1F00);
        rdc(OFS_LINK, 32'h0001_1E00, "rtu");
        wr(OFS_LINK, 32'h0);
        $display("test ids done");
    endtask

    // Entry: count[15:8] retries[6:4] ack[1] handshake[0]
    task automatic t_seq;
        logic [15:0] t [7] = '{16'h0310, 16'h0620, 16'h0930,
            16'h0333, 16'h0153, 16'h0143, 16'h0C41};
        for (int i = 0; i < 7; i++) begin
            wr(OFS_RADIO, {31'h0, t[i][0]});
            wr(OFS_TIMING, {21'h0, t[i][6:4], 8'h05});
            ack_en <= t[i][1];
            ntx = 0;
            ncfg = 0;
            go(32'h5);
            chk("tx", ntx, t[i][15:8]);
            chk("cfg", ncfg, ntx);
            rdc(OFS_CNT0, {24'h0, t[i][15:8]}, "cnt0");
        end
        ack_en <= 1'h0;
        wr(OFS_RADIO, 32'h0);
        wr(OFS_TIMING, 32'h0000_0105);
        $display("test sequences done");
    endtask

    task automatic t_net;
        mnet <= 5'h03;
        wr(OFS_CMD, 32'h5);
        repeat (100) @(posedge pclk);
        rdc(OFS_STATUS, 32'h41, "status");
        rdc(OFS_CNT0, 32'h0, "cnt0");
        mnet <= 5'h00;
        till(1'h0, 3000);
        rdc(OFS_CNT0, 32'h3, "cnt0");
        $display("test network done");
    endtask

    task automatic t_dual;
        slow <= 1'h1;
        wr(OFS_LINK, 32'h0001_0500);
        go(32'h7);
        rdc(OFS_CNT0, 32'h3, "cnt0");
        rdc(OFS_CNT1, 32'h3, "cnt1");
        chk("rtu2", rtu_ok, 1'h1);
        slow <= 1'h0;
        wr(OFS_LINK, 32'h0);
        $display("test dual done");
    endtask

    task automatic t_timer;
        logic [2:0] m [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        int s;
        wr(OFS_TIMING, 32'h0000_0101);
        for (int i = 0; i < 4; i++) begin
            alm <= m[i];
            go(32'h4);
            till(1'h1, 1400);
            s = (m[i] != 3'h0) ? 6 : 60;
            chk("gap", waited > (s - 1) * S && waited <= s * S + 5,
                1'h1);
            alm <= 3'h0;
            till(1'h0, 3000);
        end
        wr(OFS_TIMING, 32'h0000_0105);
        $display("test timer done");
    endtask

    task automatic t_power;
        wr(OFS_RADIO, 32'h10);
        wr(OFS_RADIO, 32'h30);
        // Range flag keeps its last value while the radio sleeps
        rdc(OFS_STATUS, 32'h10, "status");
        chk("pwr", radio_out.power, 3'h1);
        wr(OFS_RADIO, 32'h32);
        rdc(OFS_STATUS, 32'h10, "status");
        chk("pwr", radio_out.power, 3'h4);
        wr(OFS_CMD, 32'h1);
        up_key <= 1'h1;
        till(1'h1, 6 * S + 5);
        chk("hold", waited >= 4 * S, 1'h1);
        up_key <= 1'h0;
        till(1'h0, 3000);
        rdc(OFS_CNT0, 32'h3, "cnt0");
        m_end <= 1'h1;
        up_key <= 1'h1;
        waited = 0;
        while (flash !== 1'h1 && waited < 6 * S + 5) begin
            @(posedge pclk);
            waited++;
        end
        chk("flash", flash, 1'h1);
        up_key <= 1'h0;
        m_end <= 1'h0;
        rdc(OFS_STATUS, 32'h30, "status");
        wr(OFS_RADIO, 32'h30);
        rdc(OFS_RADIO, 32'h30, "radio");
        chk("pwr", radio_out.power, 3'h3);
        $display("test power done");
    endtask

    task automatic t_screen;
        wr(OFS_RADIO, 32'h130);
        rdc(OFS_STATUS, 32'h30, "status");
        chk("radio_on", radio_out.radio_on, 1'h1);
        mnet <= 5'h03;
        rdc(OFS_STATUS, 32'h20, "status");
        mnet <= 5'h00;
        wr(OFS_RADIO, 32'h30);
        $display("test screen done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run needs well under 10000 cycles
    initial begin
        #2_000_000;
        err_count++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_ids();
        t_seq();
        t_net();
        t_dual();
        t_timer();
        t_power();
        t_screen();
        final_report();
    end
endmodule
